// ===== rtl/ssm_pkg.sv
// ****************************************************************
// shared constants and types
// ****************************************************************
package ssm_pkg;

    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 9;

    // register byte addresses
    localparam logic [8:0]  ADR_INTCTL    = 9'h00b;
    localparam logic [8:0]  ADR_IRQFLG    = 9'h00c;
    localparam logic [8:0]  ADR_RXCTL     = 9'h018;
    localparam logic [8:0]  ADR_TXBUF     = 9'h019;
    localparam logic [8:0]  ADR_RXDATA    = 9'h01a;
    localparam logic [8:0]  ADR_IRQEN     = 9'h08c;
    localparam logic [8:0]  ADR_TXCTL     = 9'h098;
    localparam logic [8:0]  ADR_BAUD      = 9'h099;

    // values after reset
    localparam logic [7:0]  RST_INTCTL    = 8'h00;
    localparam logic [7:0]  RST_IRQFLG    = 8'h00;
    localparam logic [7:0]  RST_RXCTL     = 8'h00;
    localparam logic [7:0]  RST_TXBUF     = 8'h00;
    localparam logic [7:0]  RST_IRQEN     = 8'h00;
    localparam logic [7:0]  RST_TXCTL     = 8'h02;
    localparam logic [7:0]  RST_BAUD      = 8'h00;

    // field positions
    localparam int          TX_BUFFER_EMPTY_FLAG_BIT      = 4;
    localparam int          TX_BUFFER_EMPTY_IRQ_ENABLE_BIT      = 4;
    localparam logic [7:0]  RXCTL_WMASK   = 8'hf0;
    localparam logic [7:0]  TXCTL_WMASK   = 8'hf5;

    // clock cycles per instruction cycle
    localparam int          TCY_DIV       = 4;
    localparam int          TCY_CNT_W     = 2;

    // last bit index of a word
    localparam logic [3:0]  LAST_IDX_8    = 4'h7;
    localparam logic [3:0]  LAST_IDX_9    = 4'h8;

    typedef struct packed {
        logic clock_source_master;
        logic nine_bit_tx_select;
        logic tx_enable;
        logic synchronous_select;
        logic rsvd;
        logic high_speed;
        logic tx_shift_empty;
        logic ninth_tx_bit;
    } ssm_txctl_t;

    typedef struct packed {
        logic serial_port_enable;
        logic nine_bit_rx_select;
        logic single_rx_enable;
        logic continuous_rx_enable;
        logic [3:0] rsvd;
    } ssm_rxctl_t;

    typedef enum logic [2:0] {
        SSM_OFF = 3'b001,
        SSM_TX  = 3'b010,
        SSM_RX  = 3'b100
    } ssm_mode_t;

endpackage

// ===== rtl/ssm_baud_gen.sv
`timescale 1ns/1ps
// ****************************************************************
// baud generator: one tick every divisor+1 steps
// ****************************************************************
module ssm_baud_gen #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         hold,
    input  wire logic         step_en,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (hold) begin
            cnt_reg <= '0;
        end else if (step_en) begin
            if (cnt_reg == divisor) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= !hold && step_en && (cnt_reg == divisor);
        end
    end

    AST_BAUD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        hold |=> (cnt_reg == '0) && !tick)
        else $error("baud generator runs while held");

endmodule

// ===== rtl/ssm_sync_tx.sv
`timescale 1ns/1ps
// ****************************************************************
// ****************************************************************
module ssm_sync_tx (
    input  wire logic                         MCLK,
    input  wire logic                         ARST_N,
    input  wire logic [ssm_pkg::ADDR_W-1:0]   ADDR,
    input  wire logic [ssm_pkg::DATA_W-1:0]   WDATA,
    input  wire logic                         WR,
    input  wire logic                         RD,
    output logic      [ssm_pkg::DATA_W-1:0]   RDATA,
    output logic                              CK_O,
    output logic                              CK_OE,
    input  wire logic                         DT_I,
    output logic                              DT_O,
    output logic                              DT_OE,
    output logic                              TX_IRQ
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]                       intctl_reg;
    logic [7:0]                       irqflg_reg;
    logic                             tx_buffer_empty_flag_reg;
    logic [7:0]                       irqen_reg;
    ssm_pkg::ssm_rxctl_t              rxctl_reg;
    ssm_pkg::ssm_txctl_t              txctl_reg;
    logic [7:0]                       baud_reg;
    logic [7:0]                       txbuf_reg;
    logic                             buf_full_reg;
    logic [7:0]                       rxdata_reg;

    logic [8:0]                       tsr_reg;
    logic                             tsr_full_reg;
    logic                             tsr_nine_reg;
    logic [3:0]                       bit_idx_reg;
    logic [3:0]                       rx_idx_reg;
    logic [7:0]                       rx_shift_reg;
    logic                             ck_reg;
    logic                             dt_s1_reg;
    logic                             dt_s2_reg;
    logic [ssm_pkg::TCY_CNT_W-1:0]    tcy_cnt_reg;
    logic                             tcy_en_reg;
    ssm_pkg::ssm_mode_t               mode_reg;
    ssm_pkg::ssm_mode_t               mode_next;

    logic wr_txbuf;
    logic port_on;
    logic baud_hold;
    logic tick;
    logic shifting;
    logic rx_act;
    logic rise;
    logic fall;
    logic tx_last;
    logic rx_last;
    logic rx_done;
    logic load;
    logic tx_reset;

    function automatic logic [3:0] last_idx(input logic nine);
        return nine ? ssm_pkg::LAST_IDX_9 : ssm_pkg::LAST_IDX_8;
    endfunction

    assign wr_txbuf = WR && (ADDR == ssm_pkg::ADR_TXBUF);

    // ****************************************************************
    // port mode
    // ****************************************************************
    // slave mode is not built, so the port needs the master bit to run
    assign port_on = rxctl_reg.serial_port_enable && txctl_reg.synchronous_select
                  && txctl_reg.clock_source_master;

    always_comb begin
        mode_next = ssm_pkg::SSM_OFF;
        if (port_on) begin
            if (rxctl_reg.continuous_rx_enable || rxctl_reg.single_rx_enable) begin
                mode_next = ssm_pkg::SSM_RX;
            end else if (txctl_reg.tx_enable) begin
                mode_next = ssm_pkg::SSM_TX;
            end
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_reg <= ssm_pkg::SSM_OFF;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ****************************************************************
    // instruction cycle and baud generator
    // ****************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tcy_cnt_reg <= '0;
            tcy_en_reg  <= 1'b0;
        end else begin
            tcy_en_reg  <= (tcy_cnt_reg == ssm_pkg::TCY_CNT_W'(ssm_pkg::TCY_DIV - 1));
            tcy_cnt_reg <= tcy_cnt_reg + ssm_pkg::TCY_CNT_W'(1);
        end
    end

    assign baud_hold = !port_on || !(txctl_reg.tx_enable || rxctl_reg.continuous_rx_enable
                                     || rxctl_reg.single_rx_enable);

    ssm_baud_gen #(
        .W       (8)
    ) u_baud (
        .clk     (MCLK),
        .rst_n   (ARST_N),
        .hold    (baud_hold),
        .step_en (tcy_en_reg),
        .divisor (baud_reg),
        .tick    (tick)
    );

    assign shifting = (mode_reg == ssm_pkg::SSM_TX) && tsr_full_reg;
    assign rx_act   = (mode_reg == ssm_pkg::SSM_RX);
    assign rise     = tick && !ck_reg && (shifting || rx_act);
    assign fall     = tick && ck_reg && (shifting || rx_act);

    // clock only toggles while a word moves; parks low otherwise
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ck_reg <= 1'b0;
        end else if (mode_reg == ssm_pkg::SSM_OFF) begin
            ck_reg <= 1'b0;
        end else if (rise || fall) begin
            ck_reg <= !ck_reg;
        end
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    assign tx_reset = !txctl_reg.tx_enable;
    assign tx_last  = bit_idx_reg == last_idx(tsr_nine_reg);
    // the reload rides on the final fall so consecutive words leave no gap
    // no transfer while the enable is already low, or the flag would set with nothing loaded
    assign load     = !tx_reset
                   && ((mode_reg == ssm_pkg::SSM_TX) && buf_full_reg && tcy_en_reg && !tsr_full_reg
                       || shifting && fall && tx_last && buf_full_reg);

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tsr_reg      <= '0;
            tsr_full_reg <= 1'b0;
            tsr_nine_reg <= 1'b0;
            bit_idx_reg  <= '0;
        end else if (tx_reset) begin
            tsr_full_reg <= 1'b0;
            bit_idx_reg  <= '0;
        end else if (load) begin
            // ninth bit is taken as it stands now, so it must be written first
            tsr_reg      <= {txctl_reg.ninth_tx_bit && txctl_reg.nine_bit_tx_select, txbuf_reg};
            tsr_nine_reg <= txctl_reg.nine_bit_tx_select;
            tsr_full_reg <= 1'b1;
            bit_idx_reg  <= '0;
        end else if (shifting && fall) begin
            if (tx_last) begin
                tsr_full_reg <= 1'b0;
                bit_idx_reg  <= '0;
            end else begin
                bit_idx_reg  <= bit_idx_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            txbuf_reg    <= ssm_pkg::RST_TXBUF;
            buf_full_reg <= 1'b0;
        end else if (wr_txbuf) begin
            txbuf_reg    <= WDATA;
            buf_full_reg <= 1'b1;
        end else if (load) begin
            buf_full_reg <= 1'b0;
        end
    end

    // a write in the same cycle as a transfer refills the buffer, so it stays clear
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_buffer_empty_flag_reg <= 1'b0;
        end else if (wr_txbuf) begin
            tx_buffer_empty_flag_reg <= 1'b0;
        end else if (load) begin
            tx_buffer_empty_flag_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // receive bit counting and sampling
    // ****************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dt_s1_reg <= 1'b0;
            dt_s2_reg <= 1'b0;
        end else begin
            dt_s1_reg <= DT_I;
            dt_s2_reg <= dt_s1_reg;
        end
    end

    assign rx_last = rx_idx_reg == last_idx(rxctl_reg.nine_bit_rx_select);
    assign rx_done = rx_act && fall && rx_last;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_idx_reg   <= '0;
            rx_shift_reg <= '0;
            rxdata_reg   <= '0;
        end else if (!rx_act) begin
            rx_idx_reg   <= '0;
        end else if (fall) begin
            if (rx_idx_reg < ssm_pkg::LAST_IDX_9) begin
                rx_shift_reg <= {dt_s2_reg, rx_shift_reg[7:1]};
            end
            if (rx_last) begin
                rx_idx_reg <= '0;
                rxdata_reg <= (rx_idx_reg == ssm_pkg::LAST_IDX_8) ? {dt_s2_reg, rx_shift_reg[7:1]}
                                                                   : rx_shift_reg;
            end else begin
                rx_idx_reg <= rx_idx_reg + 4'h1;
            end
        end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            intctl_reg <= ssm_pkg::RST_INTCTL;
            irqflg_reg <= ssm_pkg::RST_IRQFLG;
            irqen_reg  <= ssm_pkg::RST_IRQEN;
            baud_reg   <= ssm_pkg::RST_BAUD;
            txctl_reg  <= ssm_pkg::RST_TXCTL & ssm_pkg::TXCTL_WMASK;
        end else if (WR) begin
            unique case (ADDR)
                ssm_pkg::ADR_INTCTL: intctl_reg <= WDATA;
                ssm_pkg::ADR_IRQFLG: irqflg_reg <= WDATA;
                ssm_pkg::ADR_IRQEN:  irqen_reg  <= WDATA;
                ssm_pkg::ADR_BAUD:   baud_reg   <= WDATA;
                ssm_pkg::ADR_TXCTL:  txctl_reg  <= WDATA & ssm_pkg::TXCTL_WMASK;
                default: ;
            endcase
        end
    end

    // a software set of single receive beats the hardware clear in one cycle
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rxctl_reg <= ssm_pkg::RST_RXCTL;
        end else if (WR && ADDR == ssm_pkg::ADR_RXCTL) begin
            rxctl_reg <= WDATA & ssm_pkg::RXCTL_WMASK;
        end else if (rx_done && !rxctl_reg.continuous_rx_enable) begin
            rxctl_reg.single_rx_enable <= 1'b0;
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= '0;
        end else if (RD) begin
            unique case (ADDR)
                ssm_pkg::ADR_INTCTL: RDATA <= intctl_reg;
                ssm_pkg::ADR_IRQFLG: RDATA <= {irqflg_reg[7:5], tx_buffer_empty_flag_reg, irqflg_reg[3:0]};
                ssm_pkg::ADR_RXCTL:  RDATA <= rxctl_reg;
                ssm_pkg::ADR_TXBUF:  RDATA <= txbuf_reg;
                ssm_pkg::ADR_RXDATA: RDATA <= rxdata_reg;
                ssm_pkg::ADR_IRQEN:  RDATA <= irqen_reg;
                ssm_pkg::ADR_TXCTL:  RDATA <= {txctl_reg[7:2], !tsr_full_reg, txctl_reg[0]};
                ssm_pkg::ADR_BAUD:   RDATA <= baud_reg;
                default:             RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    // ****************************************************************
    // pins and request
    // ****************************************************************
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DT_O   <= 1'b0;
            DT_OE  <= 1'b0;
            CK_O   <= 1'b0;
            CK_OE  <= 1'b0;
            TX_IRQ <= 1'b0;
        end else begin
            if (tx_reset) begin
                DT_O <= 1'b0;
            end else if (shifting && rise) begin
                DT_O <= tsr_reg[bit_idx_reg];
            end
            DT_OE  <= (mode_next == ssm_pkg::SSM_TX);
            CK_O   <= ck_reg;
            CK_OE  <= (mode_next != ssm_pkg::SSM_OFF);
            TX_IRQ <= tx_buffer_empty_flag_reg && irqen_reg[ssm_pkg::TX_BUFFER_EMPTY_IRQ_ENABLE_BIT];
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_HALF_DUPLEX: assert property (@(posedge MCLK) disable iff (!ARST_N)
        (mode_next == ssm_pkg::SSM_RX) |=> !DT_OE && !shifting)
        else $error("data driven while receiving");
    AST_PINS_GIVEN: assert property (@(posedge MCLK) disable iff (!ARST_N)
        !rxctl_reg.serial_port_enable |=> !DT_OE && !CK_OE)
        else $error("pins driven with port disabled");
    AST_LOAD_FLAG: assert property (@(posedge MCLK) disable iff (!ARST_N)
        load && !wr_txbuf |=> tx_buffer_empty_flag_reg && tsr_full_reg && !buf_full_reg)
        else $error("transfer did not empty buffer");
    AST_FLAG_STICKY: assert property (@(posedge MCLK) disable iff (!ARST_N)
        tx_buffer_empty_flag_reg && !wr_txbuf |=> tx_buffer_empty_flag_reg)
        else $error("empty flag cleared without buffer write");
    AST_NO_SHIFT_IDLE: assert property (@(posedge MCLK) disable iff (!ARST_N)
        !tsr_full_reg && !load |=> !tsr_full_reg && $stable(bit_idx_reg))
        else $error("shifter moved without data");
    AST_BACK2BACK: assert property (@(posedge MCLK) disable iff (!ARST_N)
        shifting && fall && tx_last && buf_full_reg && !tx_reset |-> load ##1 tsr_full_reg)
        else $error("gap between consecutive words");
    AST_ABORT_TX: assert property (@(posedge MCLK) disable iff (!ARST_N)
        $fell(txctl_reg.tx_enable) && !rx_act |=> !DT_OE && !tsr_full_reg ##1 !CK_OE)
        else $error("transmit not aborted");
    AST_RX_ABORT: assert property (@(posedge MCLK) disable iff (!ARST_N)
        port_on && rxctl_reg.continuous_rx_enable |=> CK_OE && !DT_OE)
        else $error("receive did not take the pins");
    AST_SINGLE_END: assert property (@(posedge MCLK) disable iff (!ARST_N)
        rx_done && !rxctl_reg.continuous_rx_enable && !WR && txctl_reg.tx_enable
        |=> !rxctl_reg.single_rx_enable ##1 DT_OE)
        else $error("single receive did not end");
    AST_NINTH: assert property (@(posedge MCLK) disable iff (!ARST_N)
        load && !tx_reset |=> tsr_reg[8] == $past(txctl_reg.ninth_tx_bit && txctl_reg.nine_bit_tx_select))
        else $error("ninth bit not captured");
    AST_LSB_FIRST: assert property (@(posedge MCLK) disable iff (!ARST_N)
        shifting && rise && (bit_idx_reg == 4'h0) && !tx_reset |=> DT_O == tsr_reg[0])
        else $error("first bit is not bit zero");

endmodule

// ===== dv/ssm_rx_model.sv
`timescale 1ns/1ps
// ****
// far-end synchronous receiver
// ****
module ssm_rx_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ck,
    input  wire logic       dt,
    input  wire logic       nine,
    input  wire logic       clr,
    output logic            vld,
    output logic [8:0]      word,
    output logic            dt_drv
);
    logic       ck_q;
    logic [3:0] cnt;
    logic [8:0] sh;
    logic [8:0] nsh;
    assign nsh = {dt, sh[8:1]};
    // while released, dt toggles so a stale level never passes for data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_q <= 1'b0;
            cnt <= 4'h0;
            sh <= 9'h000;
            vld <= 1'b0;
            word <= 9'h000;
            dt_drv <= 1'b0;
        end else begin
            ck_q <= ck;
            dt_drv <= ~dt_drv;
            vld <= 1'b0;
            if (clr) begin
                cnt <= 4'h0;
            end else if (ck_q && !ck) begin
                sh <= nsh;
                cnt <= cnt + 4'h1;
                if (cnt == (nine ? 4'h8 : 4'h7)) begin
                    cnt <= 4'h0;
                    vld <= 1'b1;
                    word <= nine ? nsh : {1'b0, nsh[8:1]};
                end
            end
        end
    end
endmodule

// ===== dv/ssm_sync_tx_test.sv
`timescale 1ns/1ps
// ****
// self-checking bench
// ****
module ssm_sync_tx_test;
    logic        MCLK = 1'b0;
    logic        ARST_N = 1'b0;
    logic [8:0]  ADDR = 9'h000;
    logic [7:0]  WDATA = 8'h00;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [7:0]  RDATA;
    logic        CK_O, CK_OE, DT_O, DT_OE, TX_IRQ, ck, dt, dt_drv, vld;
    logic        nine = 1'b0;
    logic        clr = 1'b0;
    logic        rd_q = 1'b0;
    logic [8:0]  word;
    logic [15:0] rnd = 16'h28c3;
    logic [7:0]  rq[$];
    logic [8:0]  wq[$];
    int          checks = 0;
    int          miscompares = 0;
    int          cyc = 0;

    always #2.5 MCLK = ~MCLK;
    // shift clock has a pull-down while floated
    assign ck = CK_OE ? CK_O : 1'b0;
    assign dt = DT_OE ? DT_O : dt_drv;

    ssm_sync_tx dut (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .CK_O(CK_O), .CK_OE(CK_OE), .DT_I(dt), .DT_O(DT_O), .DT_OE(DT_OE), .TX_IRQ(TX_IRQ));
    ssm_rx_model rxm (.clk(MCLK), .rst_n(ARST_N), .ck(ck), .dt(dt), .nine(nine), .clr(clr),
        .vld(vld), .word(word), .dt_drv(dt_drv));

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic logic [7:0] xs();
        rnd ^= rnd << 7;
        rnd ^= rnd >> 9;
        rnd ^= rnd << 8;
        return rnd[7:0];
    endfunction

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
    endtask

    task automatic send(input logic [8:0] w);
        wq.push_back(w);
        wr(ssm_pkg::ADR_TXBUF, w[7:0]);
    endtask

    task automatic drain();
        for (int i = 0; i < 3000 && wq.size() > 0; i++) @(posedge MCLK);
        cmp("words left", 9'h000, 9'(wq.size()));
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge MCLK) begin
        rd_q <= RD;
        cyc <= cyc + 1;
        if (rd_q)
            cmp("rdata", {1'b0, rq.pop_front()}, {1'b0, RDATA});
        if (vld)
            cmp("word", (wq.size() > 0) ? wq.pop_front() : 9'bx, word);
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        repeat (2) @(posedge MCLK);
        ARST_N <= 1'b1;
        rd(ssm_pkg::ADR_INTCTL, ssm_pkg::RST_INTCTL);
        rd(ssm_pkg::ADR_IRQFLG, ssm_pkg::RST_IRQFLG);
        rd(ssm_pkg::ADR_RXCTL, ssm_pkg::RST_RXCTL);
        rd(ssm_pkg::ADR_IRQEN, ssm_pkg::RST_IRQEN);
        rd(ssm_pkg::ADR_TXCTL, ssm_pkg::RST_TXCTL);
        rd(ssm_pkg::ADR_BAUD, ssm_pkg::RST_BAUD);
        rd(9'h1ff, 8'h00);
        $display("test reset done");
        wr(ssm_pkg::ADR_INTCTL, 8'hc0);
        rd(ssm_pkg::ADR_INTCTL, 8'hc0);
        wr(ssm_pkg::ADR_BAUD, 8'h01);
        wr(ssm_pkg::ADR_RXCTL, 8'h80);
        wr(ssm_pkg::ADR_TXCTL, 8'h90);
        send({1'b0, xs()});
        repeat (60) @(posedge MCLK);
        cmp("ck_oe idle", 9'h000, {8'h00, CK_OE});
        cmp("held word", 9'h001, 9'(wq.size()));
        wr(ssm_pkg::ADR_TXCTL, 8'hb0);
        repeat (10) @(posedge MCLK);
        send({1'b0, xs()});
        rd(ssm_pkg::ADR_IRQFLG, 8'h00);
        drain();
        rd(ssm_pkg::ADR_IRQFLG, 8'h10);
        rd(ssm_pkg::ADR_TXCTL, 8'hb2);
        cmp("irq off", 9'h000, {8'h00, TX_IRQ});
        wr(ssm_pkg::ADR_IRQEN, 8'h10);
        repeat (2) @(posedge MCLK);
        cmp("irq on", 9'h001, {8'h00, TX_IRQ});
        wr(ssm_pkg::ADR_IRQFLG, 8'h00);
        rd(ssm_pkg::ADR_IRQFLG, 8'h10);
        $display("test stream done");
        nine <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            wr(ssm_pkg::ADR_TXCTL, 8'hf0 | 8'(b));
            send({b[0], xs()});
            drain();
        end
        nine <= 1'b0;
        clr <= 1'b1;
        $display("test nine done");
        // aborted words are not compared
        wr(ssm_pkg::ADR_TXCTL, 8'hb0);
        wr(ssm_pkg::ADR_TXBUF, xs());
        repeat (40) @(posedge MCLK);
        wr(ssm_pkg::ADR_TXCTL, 8'h90);
        repeat (2) @(posedge MCLK);
        cmp("dt_oe", 9'h000, {8'h00, DT_OE});
        cmp("ck_oe", 9'h000, {8'h00, CK_OE});
        rd(ssm_pkg::ADR_TXCTL, 8'h92);
        wr(ssm_pkg::ADR_TXCTL, 8'hb0);
        wr(ssm_pkg::ADR_TXBUF, xs());
        repeat (40) @(posedge MCLK);
        wr(ssm_pkg::ADR_RXCTL, 8'ha0);
        repeat (2) @(posedge MCLK);
        cmp("dt_oe rx", 9'h000, {8'h00, DT_OE});
        cmp("ck_oe rx", 9'h001, {8'h00, CK_OE});
        rd(ssm_pkg::ADR_TXCTL, 8'hb0);
        for (int i = 0; i < 400 && DT_OE !== 1'b1; i++) @(posedge MCLK);
        cmp("dt_oe back", 9'h001, {8'h00, DT_OE});
        rd(ssm_pkg::ADR_RXCTL, 8'h80);
        wr(ssm_pkg::ADR_RXCTL, 8'h90);
        repeat (2) @(posedge MCLK);
        cmp("dt_oe cont", 9'h000, {8'h00, DT_OE});
        cmp("ck_oe cont", 9'h001, {8'h00, CK_OE});
        wr(ssm_pkg::ADR_RXCTL, 8'h80);
        wr(ssm_pkg::ADR_TXCTL, 8'h90);
        $display("test abort done");
        finish_test();
    end
endmodule
